// [rtl/citf_core.sv]
// citf_core: opcode sequencer, timing decode and flag update of the core
// assumes: single clk, byte-wide code memory answering in the same machine cycle
`timescale 1ns/1ps
module citf_core (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [7:0]           code_data,
    input  wire logic                 alu_cy,
    input  wire logic                 alu_ov,
    input  wire logic                 alu_ac,
    input  wire logic [1:0]           pcon_req,
    input  wire logic                 wake,
    output logic                      fetch_stb,
    output logic                      opcode_stb,
    output logic [7:0]                opcode,
    output logic [1:0]                op_bytes,
    output logic [2:0]                op_cycles,
    output citf_pkg::citf_flags_t     flags,
    output citf_pkg::citf_mode_t      mode,
    output logic                      core_clk_en,
    output logic                      periph_clk_en
);
    // -------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------
    function automatic citf_pkg::citf_timing_t dec(input logic [7:0] op);
        citf_pkg::citf_timing_t t;
        t = '{len: 2'd1, mc: 3'd1};
        if (op[3:0] == 4'h1)
            t = '{len: 2'd2, mc: 3'd3};
        else if (op[3:0] >= 4'h8 && op[7:4] == 4'hD)
            t = '{len: 2'd2, mc: 3'd3};
        else if (op[3:0] >= 4'h4 && op[7:4] == 4'hB)
            t = '{len: 2'd3, mc: 3'd4};
        else if ((op[7:4] >= 4'h2 && op[7:4] <= 4'h9 || op[7:4] == 4'hC) && op[3:0] == 4'h5 ||
                 op[7:4] >= 4'h2 && op[7:4] <= 4'h9 && op[3:0] == 4'h4 && op[7:4] != 4'h8 ||
                 op[7:4] >= 4'h4 && op[7:4] <= 4'h6 && op[3:0] == 4'h2 ||
                 op[7:4] >= 4'h7 && op[7:4] <= 4'hA && op[3:0] == 4'h2 ||
                 op[7:4] >= 4'hB && op[7:4] <= 4'hD && op[3:0] == 4'h2 ||
                 op == 8'h05 || op == 8'h15 || op == 8'hA0 || op == 8'hB0 ||
                 op == 8'hC0 || op == 8'hD0 || op == 8'hE5 || op == 8'hF5 ||
                 op[7:3] == 5'b01111 || op[7:3] == 5'b10001 || op[7:3] == 5'b10101 ||
                 op[7:1] == 7'b1000011 || op[7:1] == 7'b1010011 || op[7:1] == 7'b0111011)
            t = '{len: 2'd2, mc: 3'd2};
        if (op == 8'h75 || op == 8'h85 || op == 8'h90 || op == 8'h53 ||
            op == 8'h43 || op == 8'h63)
            t = '{len: 2'd3, mc: 3'd3};
        if (op == 8'h40 || op == 8'h50 || op == 8'h60 || op == 8'h70 || op == 8'h80)
            t = '{len: 2'd2, mc: 3'd3};
        if (op == 8'h10 || op == 8'h20 || op == 8'h30 || op == 8'hD5)
            t = '{len: 2'd3, mc: 3'd4};
        if (op == 8'h02 || op == 8'h12)
            t = '{len: 2'd3, mc: 3'd4};
        if (op == citf_pkg::OPC_MUL || op == citf_pkg::OPC_DIV)
            t = '{len: 2'd1, mc: 3'd5};
        if (op == 8'hE0 || op == 8'hE2 || op == 8'hE3 || op == 8'hF0 || op == 8'hF2 ||
            op == 8'hF3 || op == 8'h93 || op == 8'h83 || op == 8'hA3 || op == 8'hA5 ||
            op == 8'h73 || op == 8'h22 || op == 8'h32)
            t = '{len: 2'd1, mc: 3'd2};
        if (op == 8'h04 || op == 8'h14 || op[7:4] <= 4'h1 && op[3:0] >= 4'h6)
            t = '{len: 2'd1, mc: 3'd1};
        if (op == 8'hA5)
            t = '{len: 2'd1, mc: 3'd2};
        return t;
    endfunction

    function automatic logic is_cy_only(input logic [7:0] op);
        return op == citf_pkg::OPC_DA || op == citf_pkg::OPC_RLC || op == citf_pkg::OPC_RRC ||
               op == citf_pkg::OPC_CPLC || op[7:4] == 4'hB && op[3:0] >= 4'h4 ||
               op == 8'h82 || op == 8'hB0 || op == 8'h72 || op == 8'hA0 || op == 8'hA2;
    endfunction

    // -------------------------------------------------------------------
    // machine cycle phase and sequencer
    // -------------------------------------------------------------------
    logic [1:0] phase;
    logic [2:0] mc_left;
    logic [1:0] bytes_left;
    logic       run;
    logic       mc_end;
    citf_pkg::citf_timing_t cur;

    assign run = (mode == citf_pkg::CITF_NORMAL);
    assign mc_end = run && phase == 2'(citf_pkg::CLK_PER_MC - 1);
    assign cur = dec(code_data);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            phase <= 2'd0;
        else if (run)
            phase <= phase + 2'd1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mc_left    <= 3'd0;
            bytes_left <= 2'd0;
            fetch_stb  <= 1'b0;
            opcode_stb <= 1'b0;
            opcode     <= citf_pkg::RESET_BYTE;
            op_bytes   <= 2'd1;
            op_cycles  <= 3'd1;
        end
        else
        begin
            fetch_stb  <= 1'b0;
            opcode_stb <= 1'b0;
            if (mc_end)
            begin
                if (mc_left <= 3'd1)
                begin
                    opcode     <= code_data;
                    op_bytes   <= cur.len;
                    op_cycles  <= cur.mc;
                    mc_left    <= cur.mc;
                    bytes_left <= cur.len - 2'd1;
                    fetch_stb  <= 1'b1;
                    opcode_stb <= 1'b1;
                end
                else
                begin
                    mc_left <= mc_left - 3'd1;
                    if (bytes_left != 2'd0)
                    begin
                        bytes_left <= bytes_left - 2'd1;
                        fetch_stb  <= 1'b1;
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // flags
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flags <= '0;
        else if (mc_end && mc_left <= 3'd1)
        begin
            if (opcode[7:4] == 4'h2 || opcode[7:4] == 4'h3 || opcode[7:4] == 4'h9)
            begin
                if (opcode[3:0] >= 4'h4)
                    flags <= '{cy: alu_cy, ov: alu_ov, ac: alu_ac};
            end
            if (opcode == citf_pkg::OPC_CLRC)
                flags.cy <= 1'b0;
            else if (opcode == citf_pkg::OPC_SETBC)
                flags.cy <= 1'b1;
            else if (opcode == citf_pkg::OPC_MUL || opcode == citf_pkg::OPC_DIV)
            begin
                flags.cy <= 1'b0;
                flags.ov <= alu_ov;
            end
            else if (is_cy_only(opcode))
                flags.cy <= alu_cy;
            // increments and decrements fall through untouched
        end
    end

    // -------------------------------------------------------------------
    // power modes
    // -------------------------------------------------------------------
    logic pd_req;
    logic idle_req;
    assign pd_req = pcon_req[citf_pkg::PCON_PD_BIT];
    assign idle_req = pcon_req[citf_pkg::PCON_IDLE_BIT];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode          <= citf_pkg::CITF_NORMAL;
            core_clk_en   <= 1'b1;
            periph_clk_en <= 1'b1;
        end
        else
        begin
            unique case (mode)
                citf_pkg::CITF_NORMAL:
                    if (mc_end && mc_left <= 3'd1 && pd_req)
                    begin
                        mode          <= citf_pkg::CITF_PDOWN;
                        core_clk_en   <= 1'b0;
                        periph_clk_en <= 1'b0;
                    end
                    else if (mc_end && mc_left <= 3'd1 && idle_req)
                    begin
                        mode        <= citf_pkg::CITF_IDLE;
                        core_clk_en <= 1'b0;
                    end
                citf_pkg::CITF_IDLE, citf_pkg::CITF_PDOWN:
                    if (wake)
                    begin
                        mode          <= citf_pkg::CITF_NORMAL;
                        core_clk_en   <= 1'b1;
                        periph_clk_en <= 1'b1;
                    end
                default:
                    mode <= citf_pkg::CITF_NORMAL;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    fetch_spacing_a: assert property (@(posedge clk) disable iff (!arst_n)
        fetch_stb |=> !fetch_stb [*3]) else $error("fetches closer than four clocks");
    phase_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb |-> phase == 2'd0) else $error("opcode not at machine cycle start");
    mul_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode == 8'hA4 |-> op_cycles == 3'd5 && op_bytes == 2'd1)
        else $error("multiply timing wrong");
    div_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode == 8'h84 |-> op_cycles == 3'd5) else $error("divide timing wrong");
    cjne_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode[7:4] == 4'hB && opcode[3:0] >= 4'h4 |-> op_cycles == 3'd4 && op_bytes == 2'd3)
        else $error("compare jump timing wrong");
    ljmp_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h02 || opcode == 8'h12) |-> op_cycles == 3'd4)
        else $error("long jump timing wrong");
    nop_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode == 8'h00 && mode == citf_pkg::CITF_NORMAL |-> ##4 opcode_stb)
        else $error("nop not one cycle");
    mul_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 && opcode == 8'hA4 |=> !flags.cy && $stable(flags.ac))
        else $error("multiply flags wrong");
    inc_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 && opcode == 8'h04 |=> $stable(flags)) else $error("inc changed flags");
    idle_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode == citf_pkg::CITF_IDLE |-> !core_clk_en && periph_clk_en) else $error("idle clocks wrong");
    pdown_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode == citf_pkg::CITF_PDOWN |-> !core_clk_en && !periph_clk_en)
        else $error("power-down clocks wrong");
    halt_fetch_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode != citf_pkg::CITF_NORMAL |=> !fetch_stb && !opcode_stb)
        else $error("fetch while halted");
    cycle_range_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb |-> op_cycles != 3'd0 && op_cycles <= 3'(citf_pkg::MC_MAX))
        else $error("cycle count out of range");
    direct_alu_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode[3:0] == 4'h5 && (opcode[7:4] == 4'h2 || opcode[7:4] == 4'h3 || opcode[7:4] == 4'h9)
        |-> op_cycles == 3'd2 && op_bytes == 2'd2) else $error("direct arithmetic timing wrong");
    three_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h85 || opcode == 8'h75 || opcode == 8'h90 || opcode == 8'h53)
        |-> op_cycles == 3'd3 && op_bytes == 2'd3) else $error("three byte move timing wrong");
    rel_jump_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h40 || opcode == 8'h50 || opcode == 8'h60 || opcode == 8'h70 || opcode == 8'h80)
        |-> op_cycles == 3'd3 && op_bytes == 2'd2) else $error("relative jump timing wrong");
    djnz_reg_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode[7:3] == 5'b11011 |-> op_cycles == 3'd3 && op_bytes == 2'd2)
        else $error("register decrement jump timing wrong");
    djnz_direct_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && opcode == 8'hD5 |-> op_cycles == 3'd4 && op_bytes == 2'd3)
        else $error("direct decrement jump timing wrong");
    bit_jump_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h10 || opcode == 8'h20 || opcode == 8'h30)
        |-> op_cycles == 3'd4 && op_bytes == 2'd3) else $error("bit jump timing wrong");
    xdata_move_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode[7:4] == 4'hE || opcode[7:4] == 4'hF) &&
        (opcode[3:0] == 4'h0 || opcode[3:0] == 4'h2 || opcode[3:0] == 4'h3)
        |-> op_cycles == 3'd2 && op_bytes == 2'd1) else $error("external move timing wrong");
    table_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h93 || opcode == 8'h83) |-> op_cycles == 3'd2 && op_bytes == 2'd1)
        else $error("table read timing wrong");
    dptr_ops_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'hA3 || opcode == 8'hA5 || opcode == 8'h73)
        |-> op_cycles == 3'd2 && op_bytes == 2'd1) else $error("data pointer op timing wrong");
    return_cycles_a: assert property (@(posedge clk) disable iff (!arst_n)
        opcode_stb && (opcode == 8'h22 || opcode == 8'h32) |-> op_cycles == 3'd2 && op_bytes == 2'd1)
        else $error("return timing wrong");
    add_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 && (opcode[7:4] == 4'h2 || opcode[7:4] == 4'h9) && opcode[3:0] >= 4'h8 |=>
        flags.cy == $past(alu_cy) && flags.ov == $past(alu_ov) && flags.ac == $past(alu_ac))
        else $error("add or subtract flags wrong");
    carry_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 && opcode == citf_pkg::OPC_CLRC |=>
        !flags.cy && $stable(flags.ov) && $stable(flags.ac)) else $error("clear carry wrong");
    carry_set_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 && opcode == citf_pkg::OPC_SETBC |=>
        flags.cy && $stable(flags.ov) && $stable(flags.ac)) else $error("set carry wrong");
    carry_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        mc_end && mc_left <= 3'd1 &&
        (opcode == citf_pkg::OPC_DA || opcode == citf_pkg::OPC_RLC || opcode == citf_pkg::OPC_RRC) |=>
        flags.cy == $past(alu_cy) && $stable(flags.ov) && $stable(flags.ac))
        else $error("carry-only flags wrong");
endmodule

// [rtl/citf_pkg.sv]
// citf_pkg: constants and types for the instruction timing and flag core
// assumes: compiled before rtl/citf_core.sv and the bench
package citf_pkg;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_PER_MC = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_MC_MIN = 2;
    localparam int MC_MAX = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] OPC_MUL = 8'hA4;
    localparam logic [7:0] OPC_DIV = 8'h84;
    localparam logic [7:0] OPC_DA = 8'hD4;
    localparam logic [7:0] OPC_CLRC = 8'hC3;
    localparam logic [7:0] OPC_SETBC = 8'hD3;
    localparam logic [7:0] OPC_CPLC = 8'hB3;
    localparam logic [7:0] OPC_RLC = 8'h33;
    localparam logic [7:0] OPC_RRC = 8'h13;
    localparam int PCON_IDLE_BIT = 0;
    localparam int PCON_PD_BIT = 1;

    typedef enum logic [1:0] {CITF_NORMAL, CITF_IDLE, CITF_PDOWN} citf_mode_t;

    typedef struct packed {
        logic cy;
        logic ov;
        logic ac;
    } citf_flags_t;

    typedef struct packed {
        logic [1:0] len;
        logic [2:0] mc;
    } citf_timing_t;
endpackage

// [verification/citf_code_mem.sv]
// citf_code_mem: behavioural code memory that answers the core's fetches
// assumes: fetch_stb pulses once after each sampled code byte; bench fills prog
`timescale 1ns/1ps
module citf_code_mem (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       fetch_stb,
    output logic [7:0]      code_data
);
    logic [7:0]             prog [0:255];
    logic [7:0]             ptr;
    // ---------------------------------------------------------------
    // byte at the pointer, advanced once per fetch, from 0 after reset
    // ---------------------------------------------------------------
    assign code_data = prog[ptr];
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ptr <= 8'h00;
        else if (fetch_stb)
            ptr <= ptr + 8'h01;
    end
endmodule

// [verification/tb_cpu_instruction_timing_flags.sv]
// tb_cpu_instruction_timing_flags: self-checking bench of citf_core
// assumes: citf_pkg, citf_core and citf_code_mem compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin checked++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_cpu_instruction_timing_flags;
    logic                   clk = 1'b0;
    logic                   arst_n = 1'b0;
    logic [7:0]             code_data;
    logic                   alu_cy = 1'b0;
    logic                   alu_ov = 1'b0;
    logic                   alu_ac = 1'b0;
    logic [1:0]             pcon_req = 2'h0;
    logic                   wake = 1'b0;
    logic                   fetch_stb;
    logic                   opcode_stb;
    logic [7:0]             opcode;
    logic [1:0]             op_bytes;
    logic [2:0]             op_cycles;
    citf_pkg::citf_flags_t  flags;
    citf_pkg::citf_mode_t   mode;
    logic                   core_clk_en;
    logic                   periph_clk_en;
    int                     bad_count = 0;
    int                     checked = 0;
    logic [7:0] t_op [24] = '{8'h00, 8'h58, 8'h25, 8'h85, 8'hB4, 8'hBF, 8'h80, 8'h40, 8'hD8, 8'hD5, 8'h20, 8'h12,
                              8'h02, 8'hA4, 8'h84, 8'hE0, 8'hF3, 8'h93, 8'h83, 8'hA3, 8'hA5, 8'h73, 8'h22, 8'h32};
    logic [1:0] t_len [24] = '{1, 1, 2, 3, 3, 3, 2, 2, 2, 3, 3, 3, 3, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    logic [2:0] t_mc [24] = '{1, 1, 2, 3, 4, 4, 3, 3, 3, 4, 4, 4, 4, 5, 5, 2, 2, 2, 2, 2, 2, 2, 2, 2};
    logic [7:0] f_op [12] = '{8'h28, 8'h04, 8'hC3, 8'hA4, 8'hD3, 8'h33, 8'h84, 8'h98, 8'hB3, 8'hD4, 8'hB5, 8'h18};
    logic [2:0] f_alu [12] = '{7, 0, 4, 4, 2, 3, 6, 5, 3, 4, 3, 7};
    logic [2:0] f_exp [12] = '{7, 7, 3, 1, 5, 1, 3, 5, 1, 5, 1, 1};

    citf_core dut (.clk(clk), .arst_n(arst_n), .code_data(code_data), .alu_cy(alu_cy), .alu_ov(alu_ov),
        .alu_ac(alu_ac), .pcon_req(pcon_req), .wake(wake), .fetch_stb(fetch_stb), .opcode_stb(opcode_stb),
        .opcode(opcode), .op_bytes(op_bytes), .op_cycles(op_cycles), .flags(flags), .mode(mode),
        .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en));
    citf_code_mem mem (.clk(clk), .arst_n(arst_n), .fetch_stb(fetch_stb), .code_data(code_data));

    initial
    begin
        forever #(citf_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic put(input logic [7:0] op, input int len, inout int a);
        mem.prog[a] = op;
        for (int i = 1; i < len; i++)
            mem.prog[a + i] = 8'hFF;
        a = a + len;
    endtask
    task automatic do_reset();
        @(posedge clk) arst_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("rst_opcode_stb", 1'b0, opcode_stb)
        `CHK("rst_opcode", 8'h00, opcode)
        `CHK("rst_cycles", 3'h1, op_cycles)
        `CHK("rst_bytes", 2'h1, op_bytes)
        `CHK("rst_flags", 3'h0, flags)
        `CHK("rst_mode", citf_pkg::CITF_NORMAL, mode)
        `CHK("rst_core_en", 1'b1, core_clk_en)
        `CHK("rst_periph_en", 1'b1, periph_clk_en)
        @(posedge clk) arst_n <= 1'b1;
    endtask
    task automatic wait_op();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (opcode_stb !== 1'b1 && n < 40);
        `CHK("opcode_stb", 1'b1, opcode_stb)
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_timing();
        int a, k, n, f;
        a = 0;
        for (k = 0; k < 24; k++)
            put(t_op[k], t_len[k], a);
        do_reset();
        wait_op();
        for (k = 0; k < 24; k++)
        begin
            `CHK("opcode", t_op[k], opcode)
            `CHK("op_bytes", t_len[k], op_bytes)
            `CHK("op_cycles", t_mc[k], op_cycles)
            n = 0;
            f = 1;
            do
            begin
                @(negedge clk);
                n++;
                if (fetch_stb === 1'b1 && opcode_stb !== 1'b1)
                    f++;
            end
            while (opcode_stb !== 1'b1 && n < 40);
            `CHK("op_clocks", t_mc[k] * citf_pkg::CLK_PER_MC, n)
            `CHK("op_fetches", t_len[k], f)
        end
        $display("test timing done");
    endtask
    task automatic test_flags();
        int a, k;
        a = 0;
        for (k = 0; k < 12; k++)
            put(f_op[k], (f_op[k] == 8'hB5) ? 3 : 1, a);
        mem.prog[a] = 8'h00;
        do_reset();
        wait_op();
        for (k = 0; k < 12; k++)
        begin
            @(posedge clk) {alu_cy, alu_ov, alu_ac} <= f_alu[k];
            wait_op();
            @(negedge clk);
            `CHK("flags", f_exp[k], flags)
        end
        $display("test flags done");
    endtask
    task automatic test_power();
        logic [1:0] req [3] = '{2'h1, 2'h2, 2'h3};
        citf_pkg::citf_mode_t ex;
        int k, n, f;
        do_reset();
        wait_op();
        for (k = 0; k < 3; k++)
        begin
            ex = req[k][1] ? citf_pkg::CITF_PDOWN : citf_pkg::CITF_IDLE;
            @(posedge clk) pcon_req <= req[k];
            n = 0;
            while (mode !== ex && n < 40)
            begin
                @(negedge clk);
                n++;
            end
            `CHK("mode_low", ex, mode)
            `CHK("core_en", 1'b0, core_clk_en)
            `CHK("periph_en", ~req[k][1], periph_clk_en)
            @(posedge clk) pcon_req <= 2'h0;
            @(negedge clk);
            f = 0;
            repeat (16) @(negedge clk) f += (fetch_stb === 1'b1);
            `CHK("halted_fetches", 0, f)
            @(posedge clk) wake <= 1'b1;
            n = 0;
            while (mode !== citf_pkg::CITF_NORMAL && n < 40)
            begin
                @(negedge clk);
                n++;
            end
            @(posedge clk) wake <= 1'b0;
            wait_op();
            `CHK("mode_back", citf_pkg::CITF_NORMAL, mode)
            `CHK("core_en_back", 1'b1, core_clk_en)
        end
        $display("test power done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem.prog[i] = 8'h00;
        test_timing();
        test_flags();
        test_power();
        print_verdict();
    end
    initial
    begin
        #(20000 * citf_pkg::CLK_PERIOD_NS);
        bad_count++;
        print_verdict();
    end
endmodule
